// file: include/hbd_pkg.sv
// Shared constants and types for the host bus data and arbitration block
package hbd_pkg;
   localparam int DATA_W      = 64;
   localparam int GRP_W       = 16;
   localparam int GRP_N       = 4;
   localparam int BSEL_W      = 3;
   localparam int FIFO_DEPTH  = 8;
   localparam int SYNC_STAGES = 2;
   localparam int RST_DROP_CLKS = 2;
   localparam logic [BSEL_W-1:0] BSEL_RST = 3'h0;
   localparam logic [1:0] XFER_BEATS = 2'h3;

   typedef struct packed {
      logic [DATA_W-1:0] data;
   } hbd_word_t;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [GRP_N-1:0]  inv;
   } hbd_beat_t;

   typedef struct packed {
      logic data_bus_in_use_n;
      logic hit;
      logic snoop_hit_modified_n;
      logic lock;
   } hbd_obs_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_REQ  = 3'b001,
      ST_WAIT = 3'b011,
      ST_DATA = 3'b010,
      ST_HALT = 3'b110
   } hbd_state_t;

   function automatic logic [4:0] hbd_popcnt16(input logic [GRP_W-1:0] v);
      logic [4:0] c;
      c = 5'h00;
      for (int i = 0; i < GRP_W; i++) begin
         c = c + {4'h0, v[i]};
      end
      return c;
   endfunction
endpackage

// file: rtl/hbd_sync.sv
// Two-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module hbd_sync
   import hbd_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Levels
   input  wire logic [W-1:0] din,
   output      logic [W-1:0] dout
);
   logic [W-1:0] s1_r, s1_nxt, s2_r, s2_nxt;

   initial begin
      if (W < 1) $error("hbd_sync: width must be positive");
   end

   always_comb begin
      s1_nxt = din;
      s2_nxt = s1_r;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s1_r <= '1;
         s2_r <= '1;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end

   assign dout = s2_r;
endmodule

// file: rtl/hbd_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module hbd_fifo
   import hbd_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Fill side
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]      cnt_r, cnt_nxt;
   logic             push, pop;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("hbd_fifo: depth must be a power of two");
   end

   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      mem_nxt = mem_r;
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = in_data;
         wp_nxt = wp_r + 1'b1;
      end
      if (pop) begin
         rp_nxt = rp_r + 1'b1;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
      mem_r <= mem_nxt;
   end
endmodule

// file: rtl/hbd_core.sv
// Host bus arbitration and quad-pumped data phase, device side
//
// What this block does
// - While the priority request is seen active, no new request is issued except inside a lock.
// - The device asks for the bus on its own symmetric request output.
// - The device drives a three-bit frequency select that all agents follow.
// - Data splits into four 16-bit groups, group n latched by strobe pair n.
// - A group is sent inverted when more than half its bits would otherwise toggle.
// - Inversion flag n is active exactly when group n is inverted; received groups are restored.
// - The data driver marks each valid transfer with data-ready.
// - The data driver holds data-busy while it owns the data bus.
// - Both snoop lines together request a snoop stall; reasserting them extends it.
// - Internal fault output stays active until reset, bus initialise or initialise.
// - An internal fault raised while the state machine is idle is followed by a halt notice transaction.
// - The device drives data input power control during frequency switching.
// - On reset all bus outputs drop within two bus clocks.
`timescale 1ns/1ps
module hbd_core
   import hbd_pkg::*;
#(
   parameter int DW = DATA_W
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // Link clock from the bus
   input  wire logic                bus_clk,
   // Arbitration
   input  wire logic                priority_bus_request_n,
   output      logic                symmetric_bus_request_n,
   input  wire logic                bus_lock_n,
   input  wire logic                order_n_a,
   output      logic                order_n_a_seen,
   // Frequency select and input power
   input  wire logic [BSEL_W-1:0]   freq_sel_cfg,
   input  wire logic                freq_switch,
   output      logic [BSEL_W-1:0]   bus_freq_select,
   output      logic                data_input_power_ctl_n,
   // Snoop
   input  wire logic                snoop_hit_n_i,
   input  wire logic                snoop_hit_modified_n_i,
   input  wire logic                snoop_stall_req,
   output      logic                snoop_hit_n_o,
   output      logic                snoop_hit_modified_n_o,
   output      logic                snoop_hit_oe,
   output      logic                snoop_stalled,
   // Errors and initialisation
   input  wire logic                fault_event,
   input  wire logic                bus_initialize_n,
   input  wire logic                init_n,
   output      logic                internal_fault_n,
   output      logic                halt_notice_transaction,
   // Data pins
   input  wire logic [DW-1:0]       data_n_i,
   output      logic [DW-1:0]       data_n_o,
   output      logic                data_oe,
   input  wire logic [GRP_N-1:0]    group_invert_flag_n_i,
   output      logic [GRP_N-1:0]    group_invert_flag_n_o,
   input  wire logic [GRP_N-1:0]    data_strobe_pos_n_i,
   input  wire logic [GRP_N-1:0]    data_strobe_neg_n_i,
   output      logic [GRP_N-1:0]    data_strobe_pos_n_o,
   output      logic [GRP_N-1:0]    data_strobe_neg_n_o,
   input  wire logic                data_valid_n_i,
   output      logic                data_valid_n_o,
   input  wire logic                data_bus_in_use_n_i,
   output      logic                data_bus_in_use_n_o,
   output      logic                ctl_oe,
   // User write stream
   input  wire logic                wr_valid,
   output      logic                wr_ready,
   input  wire logic [DW-1:0]       wr_data,
   // User read stream
   output      logic                rd_valid,
   output      logic [DW-1:0]       rd_data
);
   initial begin
      if (DW != GRP_N * GRP_W) $error("hbd_core: data width must be four 16-bit groups");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   localparam int SW = 8 + 2 * GRP_N;
   logic [SW-1:0] raw, syn;
   logic bclk_s, priority_bus_request_n_s, lock_s, order_n_a_s, hit_s, snoop_hit_modified_n_s, data_valid_n_s, data_bus_in_use_n_s;
   logic [GRP_N-1:0] stp_s, stn_s;

   assign raw = {bus_clk, priority_bus_request_n, bus_lock_n, order_n_a,
                 snoop_hit_n_i, snoop_hit_modified_n_i, data_valid_n_i,
                 data_bus_in_use_n_i, data_strobe_pos_n_i, data_strobe_neg_n_i};

   hbd_sync #(.W(SW)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     (raw),
      .dout    (syn)
   );

   assign {bclk_s, priority_bus_request_n_s, lock_s, order_n_a_s, hit_s, snoop_hit_modified_n_s, data_valid_n_s, data_bus_in_use_n_s, stp_s, stn_s} = syn;

   // Data pins are sampled twice before use
   logic [DW-1:0]    d1_r, d2_r;
   logic [GRP_N-1:0] i1_r, i2_r;
   always_ff @(posedge clk) begin
      d1_r <= data_n_i;
      d2_r <= d1_r;
      i1_r <= group_invert_flag_n_i;
      i2_r <= i1_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge detect on link clock and strobes
   logic             bclk_q_r;
   logic [GRP_N-1:0] stp_q_r, stn_q_r;
   logic             bclk_rise;
   logic [GRP_N-1:0] stb_edge;

   always_ff @(posedge clk) begin
      bclk_q_r <= bclk_s;
      stp_q_r  <= stp_s;
      stn_q_r  <= stn_s;
   end
   assign bclk_rise = bclk_s && !bclk_q_r;
   assign stb_edge  = (stp_q_r & ~stp_s) | (stn_q_r & ~stn_s);

   ////////////////////////////////////////////////////////////////////////////
   // Write FIFO
   logic          f_valid, f_ready;
   logic [DW-1:0] f_data;

   hbd_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration and data driver state
   hbd_state_t       st_r, st_nxt;
   logic [1:0]       beat_r, beat_nxt;
   logic [DW-1:0]    last_r, last_nxt;
   logic [DW-1:0]    dout_r, dout_nxt;
   logic [GRP_N-1:0] inv_r, inv_nxt;
   logic             fault_r, fault_nxt;
   logic             halt_r, halt_nxt;
   logic             stall_r, stall_nxt;
   logic             order_n_a_r, order_n_a_nxt;
   logic             stbp_r, stbp_nxt;
   logic             drive_r, drive_nxt;
   logic [BSEL_W-1:0] bsel_r, bsel_nxt;
   logic             data_input_power_ctl_n_r, data_input_power_ctl_n_nxt;
   logic [1:0]       rst_cnt_r, rst_cnt_nxt;
   logic             pri_hold, in_lock, bus_free;

   assign pri_hold = !priority_bus_request_n_s;
   assign in_lock  = !lock_s;
   assign bus_free = data_bus_in_use_n_s;

   always_comb begin
      st_nxt      = st_r;
      beat_nxt    = beat_r;
      last_nxt    = last_r;
      dout_nxt    = dout_r;
      inv_nxt     = inv_r;
      fault_nxt   = fault_r;
      halt_nxt    = 1'b0;
      stall_nxt   = stall_r;
      order_n_a_nxt   = order_n_a_r;
      stbp_nxt    = stbp_r;
      drive_nxt   = drive_r;
      bsel_nxt    = freq_sel_cfg;
      data_input_power_ctl_n_nxt    = !freq_switch;
      rst_cnt_nxt = (rst_cnt_r == '0) ? rst_cnt_r : rst_cnt_r - 2'h1;
      f_ready     = 1'b0;
      if (fault_event) begin
         fault_nxt = 1'b1;
      end else if (!bus_initialize_n || !init_n) begin
         fault_nxt = 1'b0;
      end
      if (bclk_rise) begin
         if (!hit_s && !snoop_hit_modified_n_s) begin
            stall_nxt = 1'b1;
         end else begin
            stall_nxt = 1'b0;
         end
         if (!order_n_a_s) begin
            order_n_a_nxt = 1'b1;
         end
      end
      case (st_r)
         ST_IDLE: begin
            drive_nxt = 1'b0;
            if (fault_nxt && !fault_r) begin
               st_nxt = ST_HALT;
            end else if (f_valid && (!pri_hold || in_lock)) begin
               st_nxt = ST_REQ;
               order_n_a_nxt = 1'b0;
            end
         end
         ST_REQ: begin
            if (pri_hold && !in_lock) begin
               st_nxt = ST_IDLE;
            end else if (bclk_rise) begin
               st_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (bclk_rise && bus_free && !stall_r) begin
               st_nxt    = ST_DATA;
               beat_nxt  = '0;
               drive_nxt = 1'b1;
            end
         end
         ST_DATA: begin
            if (bclk_rise) begin
               for (int g = 0; g < GRP_N; g++) begin
                  if (hbd_popcnt16(f_data[g*GRP_W +: GRP_W] ^ last_r[g*GRP_W +: GRP_W])
                      > 5'(GRP_W / 2)) begin
                     dout_nxt[g*GRP_W +: GRP_W] = ~f_data[g*GRP_W +: GRP_W];
                     inv_nxt[g] = 1'b1;
                  end else begin
                     dout_nxt[g*GRP_W +: GRP_W] = f_data[g*GRP_W +: GRP_W];
                     inv_nxt[g] = 1'b0;
                  end
               end
               last_nxt = dout_nxt;
               f_ready  = 1'b1;
               stbp_nxt = !stbp_r;
               beat_nxt = beat_r + 2'h1;
               if (beat_r == XFER_BEATS || !f_valid) begin
                  st_nxt = ST_IDLE;
               end
            end
         end
         ST_HALT: begin
            halt_nxt = 1'b1;
            st_nxt   = ST_IDLE;
         end
         default: st_nxt = ST_IDLE;
      endcase
      if (!f_valid && st_r == ST_DATA) begin
         f_ready = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r      <= ST_IDLE;
         beat_r    <= '0;
         last_r    <= '0;
         dout_r    <= '0;
         inv_r     <= '0;
         fault_r   <= 1'b0;
         halt_r    <= 1'b0;
         stall_r   <= 1'b0;
         order_n_a_r   <= 1'b0;
         stbp_r    <= 1'b0;
         drive_r   <= 1'b0;
         bsel_r    <= BSEL_RST;
         data_input_power_ctl_n_r    <= 1'b1;
         rst_cnt_r <= 2'(RST_DROP_CLKS);
      end else begin
         st_r      <= st_nxt;
         beat_r    <= beat_nxt;
         last_r    <= last_nxt;
         dout_r    <= dout_nxt;
         inv_r     <= inv_nxt;
         fault_r   <= fault_nxt;
         halt_r    <= halt_nxt;
         stall_r   <= stall_nxt;
         order_n_a_r   <= order_n_a_nxt;
         stbp_r    <= stbp_nxt;
         drive_r   <= drive_nxt;
         bsel_r    <= bsel_nxt;
         data_input_power_ctl_n_r    <= data_input_power_ctl_n_nxt;
         rst_cnt_r <= rst_cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive path
   logic [DW-1:0] rd_r, rd_nxt;
   logic          rv_r, rv_nxt;

   always_comb begin
      rd_nxt = rd_r;
      rv_nxt = 1'b0;
      for (int g = 0; g < GRP_N; g++) begin
         if (stb_edge[g] && !drive_r) begin
            rd_nxt[g*GRP_W +: GRP_W] = !i2_r[g] ? d2_r[g*GRP_W +: GRP_W]
                                                : ~d2_r[g*GRP_W +: GRP_W];
         end
      end
      if (stb_edge[GRP_N-1] && !drive_r && !data_valid_n_s) begin
         rv_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_r <= '0;
         rv_r <= 1'b0;
      end else begin
         rd_r <= rd_nxt;
         rv_r <= rv_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   logic bus_ok;
   assign bus_ok = !sys_rst;

   assign symmetric_bus_request_n = !(bus_ok && (st_r == ST_REQ || st_r == ST_WAIT
                                     || st_r == ST_DATA));
   assign bus_freq_select        = bsel_r;
   assign data_input_power_ctl_n = data_input_power_ctl_n_r;
   assign order_n_a_seen             = order_n_a_r;
   assign snoop_stalled          = stall_r;
   assign snoop_hit_oe           = bus_ok && snoop_stall_req;
   assign snoop_hit_n_o          = !snoop_hit_oe;
   assign snoop_hit_modified_n_o = !snoop_hit_oe;
   assign internal_fault_n       = !fault_r;
   assign halt_notice_transaction = halt_r;
   assign data_oe                = bus_ok && drive_r;
   assign ctl_oe                 = bus_ok && drive_r;
   assign data_n_o               = ~dout_r;
   assign group_invert_flag_n_o  = ~inv_r;
   assign data_strobe_pos_n_o    = {GRP_N{!stbp_r}};
   assign data_strobe_neg_n_o    = {GRP_N{stbp_r}};
   assign data_valid_n_o         = !(drive_r && st_r == ST_DATA);
   assign data_bus_in_use_n_o    = !drive_r;
   assign rd_valid               = rv_r;
   assign rd_data                = rd_r;
endmodule

// file: test/hbd_core_props.sv
// Checks on the host bus block ports
`timescale 1ns/1ps
module hbd_core_props (
   // Clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // Arbitration
   input wire logic       priority_bus_request_n,
   input wire logic       symmetric_bus_request_n,
   input wire logic       bus_lock_n,
   // Frequency and power
   input wire logic [2:0] freq_sel_cfg,
   input wire logic       freq_switch,
   input wire logic [2:0] bus_freq_select,
   input wire logic       data_input_power_ctl_n,
   // Snoop
   input wire logic       snoop_stall_req,
   input wire logic       snoop_hit_n_o,
   input wire logic       snoop_hit_modified_n_o,
   input wire logic       snoop_hit_oe,
   // Faults
   input wire logic       fault_event,
   input wire logic       bus_initialize_n,
   input wire logic       init_n,
   input wire logic       internal_fault_n,
   input wire logic       halt_notice_transaction,
   // Data control
   input wire logic       data_oe,
   input wire logic       ctl_oe,
   input wire logic       data_valid_n_o,
   input wire logic       data_bus_in_use_n_o
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence halt_pulse_s;
      halt_notice_transaction ##1 !halt_notice_transaction;
   endsequence

   freq_follow_a: assert property (
      !$past(sys_rst) |-> bus_freq_select == $past(freq_sel_cfg))
      else $error("bad freq select");
   power_ctl_a: assert property (
      !$past(sys_rst) |-> data_input_power_ctl_n == !$past(freq_switch))
      else $error("bad power ctl");
   fault_sticky_a: assert property (
      !internal_fault_n && bus_initialize_n && init_n |=> !internal_fault_n)
      else $error("fault dropped");
   fault_set_a: assert property (fault_event |=> !internal_fault_n)
      else $error("fault output not raised");
   fault_clear_a: assert property (
      (!bus_initialize_n || !init_n) && !fault_event |-> ##[1:2] internal_fault_n)
      else $error("fault output not cleared");
   halt_notice_a: assert property ($fell(internal_fault_n) |-> ##[0:2] halt_pulse_s)
      else $error("no halt notice");
   snoop_stall_a: assert property (
      snoop_stall_req[*2] |-> snoop_hit_oe && !snoop_hit_n_o && !snoop_hit_modified_n_o)
      else $error("snoop stall not driven");
   request_hold_a: assert property (
      (!priority_bus_request_n && bus_lock_n)[*4] |-> !$fell(symmetric_bus_request_n))
      else $error("request under priority");
   reset_drop_a: assert property (disable iff (1'b0)
      sys_rst[*2] |-> !data_oe && !ctl_oe && !snoop_hit_oe && symmetric_bus_request_n)
      else $error("driven in reset");
   busy_with_valid_a: assert property (
      ctl_oe && !data_valid_n_o |-> !data_bus_in_use_n_o)
      else $error("ready without busy");
endmodule

bind hbd_core hbd_core_props chk (.*);

// file: test/hbd_chipset_model.sv
// Chipset agent model
`timescale 1ns/1ps
module hbd_chipset_model
   import hbd_pkg::*;
(
   // Device side
   input wire logic              clk,
   input wire logic              data_oe,
   input wire logic              dev_busy_n,
   input wire logic              bus_lock_n,
   input wire logic [DATA_W-1:0] dev_data_n,
   input wire logic [GRP_N-1:0]  dev_flag_n,
   input wire logic [GRP_N-1:0]  dev_spos_n,
   input wire logic [GRP_N-1:0]  dev_sneg_n,
   // Agent drive, idle high
   output logic                  prio_n,
   output logic                  snoop_n,
   output logic                  order_n,
   output logic                  valid_n,
   output logic                  busy_n,
   output logic [DATA_W-1:0]     data_n,
   output logic [GRP_N-1:0]      flag_n,
   output logic [GRP_N-1:0]      spos_n
);
   hbd_beat_t        cap_q[$];
   hbd_beat_t        part;
   logic [GRP_N-1:0] spos_r;
   logic [GRP_N-1:0] sneg_r;

   initial begin
      {prio_n, snoop_n, order_n, valid_n, busy_n} = 5'h1F;
      data_n = '1;
      flag_n = '1;
      spos_n = '1;
      part = '0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Capture per strobe pair
   always @(posedge clk) begin
      for (int g = 0; g < GRP_N; g++) begin
         if (data_oe && (dev_spos_n[g] != spos_r[g] || dev_sneg_n[g] != sneg_r[g])) begin
            part.data[g*GRP_W +: GRP_W] = dev_data_n[g*GRP_W +: GRP_W];
            part.inv[g] = dev_flag_n[g];
            if (g == GRP_N-1) begin
               cap_q.push_back(part);
            end
         end
      end
      spos_r <= dev_spos_n;
      sneg_r <= dev_sneg_n;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic grab();
      while (bus_lock_n !== 1'b1) @(posedge clk);
      @(posedge clk) #1 prio_n = 0;
   endtask

   task automatic drop();
      @(posedge clk) #1 prio_n = 1;
   endtask

   task automatic send_word(input logic [DATA_W-1:0] w, input logic [GRP_N-1:0] inv);
      while (dev_busy_n !== 1'b1) @(posedge clk);
      @(posedge clk) #1;
      busy_n = 0;
      valid_n = 0;
      flag_n = ~inv;
      data_n = ~w ^ {{GRP_W{inv[3]}}, {GRP_W{inv[2]}}, {GRP_W{inv[1]}}, {GRP_W{inv[0]}}};
      repeat (4) @(posedge clk);
      #1 spos_n = '0;
      repeat (8) @(posedge clk);
      #1 spos_n = '1;
      {valid_n, busy_n} = 2'h3;
      data_n = '1;
      flag_n = '1;
   endtask

   task automatic snoop(input logic v);
      @(posedge clk) #1 snoop_n = v;
   endtask

   task automatic order_pulse();
      @(posedge clk) #1 order_n = 0;
      repeat (16) @(posedge clk);
      #1 order_n = 1;
   endtask
endmodule

// file: test/host_bus_data_arbitration_bench.sv
// Self-checking bench for the host bus block
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("Error %0t got %0h exp %0h", $time, got, exp); \
      end \
   end
module host_bus_data_arbitration_bench
   import hbd_pkg::*;
;
   localparam logic [DATA_W-1:0] PATS [8] = '{64'h0, 64'hFFFFFFFFFFFFFFFF,
      64'h00FF00FF00FF00FF, 64'hFF00FFFF0000FF01, 64'h123456789ABCDEF0,
      64'hEDCBA9876543210F, 64'h0, 64'h7FFF8000FFFE0001};
   logic clk, sys_rst, bus_clk, bus_lock_n, freq_switch, snoop_stall_req, fault_event;
   logic bus_initialize_n, init_n, wr_valid, wr_ready, rd_valid;
   logic [2:0] freq_sel_cfg, bus_freq_select;
   logic [DATA_W-1:0] wr_data, rd_data, data_n_o, pm_data_n, rd_got;
   logic symmetric_bus_request_n, order_n_a_seen, data_input_power_ctl_n, snoop_stalled;
   logic snoop_hit_n_o, snoop_hit_modified_n_o, snoop_hit_oe, internal_fault_n;
   logic halt_notice_transaction, data_oe, data_valid_n_o, data_bus_in_use_n_o, ctl_oe;
   logic [GRP_N-1:0] group_invert_flag_n_o, data_strobe_pos_n_o, data_strobe_neg_n_o;
   logic priority_bus_request_n, order_n_a, snoop_n, pm_valid_n, pm_busy_n;
   logic [GRP_N-1:0] pm_flag_n, pm_spos_n;
   int n_mismatch, checks, halt_cnt, rd_cnt;
   wire logic snoop_hit_n_i = (snoop_hit_oe ? snoop_hit_n_o : 1'b1) & snoop_n;
   wire logic snoop_hit_modified_n_i = (snoop_hit_oe ? snoop_hit_modified_n_o : 1'b1) & snoop_n;
   wire logic dev_busy_n = ctl_oe ? data_bus_in_use_n_o : 1'b1;
   wire logic data_bus_in_use_n_i = dev_busy_n & pm_busy_n;
   wire logic data_valid_n_i = (ctl_oe ? data_valid_n_o : 1'b1) & pm_valid_n;
   wire logic [DATA_W-1:0] data_n_i = (data_oe ? data_n_o : '1) & pm_data_n;
   wire logic [GRP_N-1:0] group_invert_flag_n_i = (data_oe ? group_invert_flag_n_o : '1) & pm_flag_n;
   wire logic [GRP_N-1:0] data_strobe_pos_n_i = (data_oe ? data_strobe_pos_n_o : '1) & pm_spos_n;
   wire logic [GRP_N-1:0] data_strobe_neg_n_i = data_oe ? data_strobe_neg_n_o : '1;

   hbd_core uut (.*);
   hbd_chipset_model pm (
      .clk, .data_oe, .dev_busy_n, .bus_lock_n, .dev_data_n(data_n_o),
      .dev_flag_n(group_invert_flag_n_o), .dev_spos_n(data_strobe_pos_n_o),
      .dev_sneg_n(data_strobe_neg_n_o), .prio_n(priority_bus_request_n), .snoop_n,
      .order_n(order_n_a), .valid_n(pm_valid_n), .busy_n(pm_busy_n), .data_n(pm_data_n),
      .flag_n(pm_flag_n), .spos_n(pm_spos_n)
   );

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      bus_clk = 0;
      #7;
      forever #100 bus_clk = ~bus_clk;
   end
   always @(posedge clk) begin
      if (halt_notice_transaction === 1'b1) halt_cnt++;
      if (rd_valid === 1'b1) begin
         rd_cnt++;
         rd_got = rd_data;
      end
   end

   function automatic int ones(input logic [GRP_W-1:0] v);
      ones = 0;
      for (int i = 0; i < GRP_W; i++) ones += v[i];
   endfunction
   function automatic logic [DATA_W-1:0] spread(input logic [GRP_N-1:0] m);
      for (int g = 0; g < GRP_N; g++) spread[g*GRP_W +: GRP_W] = {GRP_W{m[g]}};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      `CHK(bus_freq_select, 3'h0)
      `CHK({internal_fault_n, symmetric_bus_request_n, data_oe, ctl_oe, snoop_hit_oe}, 5'h18)
      $display("t_reset done");
   endtask

   task automatic t_read();
      pm.send_word(64'h0123_4567_89AB_CDEF, 4'h0);
      tick(6);
      `CHK(rd_got, 64'h0123_4567_89AB_CDEF)
      pm.send_word(64'hFEDC_0000_FFFF_1357, 4'hA);
      tick(6);
      `CHK(rd_got, 64'hFEDC_0000_FFFF_1357)
      `CHK(rd_cnt, 2)
      $display("t_read done");
   endtask

   task automatic t_write();
      hbd_beat_t b;
      logic [DATA_W-1:0] prev;
      int n;
      pm.grab();
      tick(4);
      wr_valid = 1;
      for (n = 0; n < 12 && wr_ready === 1'b1; n++) begin
         wr_data = PATS[n % 8];
         tick(1);
      end
      wr_valid = 0;
      `CHK(n, 8)
      `CHK(symmetric_bus_request_n, 1'b1)
      pm.drop();
      for (n = 0; n < 100 && symmetric_bus_request_n !== 1'b0; n++) tick(1);
      `CHK(symmetric_bus_request_n, 1'b0)
      for (n = 0; n < 3000 && pm.cap_q.size() < 8; n++) tick(1);
      `CHK(pm.cap_q.size(), 8)
      `CHK(wr_ready, 1'b1)
      prev = '1;
      for (int i = 0; i < 8; i++) begin
         b = pm.cap_q[i];
         `CHK(~b.data ^ spread(~b.inv), PATS[i])
         for (int g = 0; g < GRP_N; g++) begin
            if (i > 0) `CHK(~b.inv[g], ones(prev[g*GRP_W +: GRP_W] ^ ~PATS[i][g*GRP_W +: GRP_W]) > 8)
         end
         prev = b.data;
      end
      $display("t_write done");
   endtask

   task automatic t_misc();
      for (int i = 0; i < 8; i++) begin
         freq_sel_cfg = 3'(i);
         tick(2);
         `CHK(bus_freq_select, 3'(i))
      end
      freq_switch = 1;
      tick(2);
      `CHK(data_input_power_ctl_n, 1'b0)
      freq_switch = 0;
      snoop_stall_req = 1;
      tick(3);
      `CHK({data_input_power_ctl_n, snoop_hit_oe, snoop_hit_n_o, snoop_hit_modified_n_o}, 4'hC)
      snoop_stall_req = 0;
      pm.snoop(1'b0);
      tick(30);
      `CHK(snoop_stalled, 1'b1)
      pm.snoop(1'b1);
      tick(30);
      `CHK(snoop_stalled, 1'b0)
      pm.order_pulse();
      tick(4);
      `CHK(order_n_a_seen, 1'b1)
      $display("t_misc done");
   endtask

   task automatic t_fault();
      for (int k = 0; k < 3; k++) begin
         fault_event = 1;
         tick(1);
         fault_event = 0;
         tick(6);
         `CHK(internal_fault_n, 1'b0)
         `CHK(halt_cnt, k + 1)
         if (k == 0) bus_initialize_n = 0;
         if (k == 1) init_n = 0;
         if (k == 2) sys_rst = 1;
         tick(2);
         {bus_initialize_n, init_n, sys_rst} = 3'h6;
         tick(3);
         `CHK(internal_fault_n, 1'b1)
      end
      $display("t_fault done");
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {bus_lock_n, bus_initialize_n, init_n, sys_rst} = 4'hF;
      {freq_switch, snoop_stall_req, fault_event, wr_valid} = 4'h0;
      freq_sel_cfg = 3'h0;
      wr_data = '0;
      repeat (20) @(posedge clk);
      #1;
      t_reset();
      sys_rst = 0;
      tick(4);
      t_read();
      t_write();
      t_misc();
      t_fault();
      tally_and_finish();
   end
   initial begin
      #400000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule
